// file: rtl/hsr_host_strobe_read.sv
// host strobe registers, read order table and indirect readback path
//
// Function
// - test strobe write pulses selected input enable
// - sync strobe write gives one-cycle pulse
// - sync path tolerates two pipeline stages
// - read order entries hold channel and type
// - types 0-3 return I and Q halves
// - types 4-7 return magnitude, phase, gain
// - indirect read address written at address 3
// - strobed sources fetched on address write
// - strobeless sources read live at 0/1
// - separate write samples all gains together
// - channel nibble 0-3 or F valid
// - offsets 6, 9, C map oscillator, wait
// - address F806 returns level detector output
// - test input register feeds sample inputs
`timescale 1ns/1ps
module hsr_host_strobe_read
    import hsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host port pins
    input wire logic host_cs_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic [2:0] host_addr,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe_n,
    // channel configuration bits and datapath sources
    input wire logic [3:0] strobe_select,
    input wire logic [3:0] enable_level,
    input wire logic [3:0][31:0] carrier_freq,
    input wire logic [3:0][31:0] timing_freq,
    input wire logic [3:0][31:0] wait_values,
    input wire logic [3:0][15:0] agc_gain,
    input wire logic [3:0][23:0] path_i,
    input wire logic [3:0][23:0] path_q,
    input wire logic [3:0][23:0] path_mag,
    input wire logic [3:0][15:0] path_phase,
    input wire logic [31:0] level_out,
    // read order lookup
    input wire logic [4:0] order_index,
    output logic [15:0] order_data,
    // strobes and pins
    output logic [15:0] test_input,
    output logic [3:0] input_enable_strobe,
    output logic sync_out_pin,
    output logic fetch_strobe,
    output logic agc_sample_strobe
);
    // synchroniser stages for host pins
    logic [21:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic wr_end, s_cs_n, s_rd_n;
    logic [2:0] s_addr;
    logic [15:0] s_data;

    // two flip-flops on all host pins, then edge detect on the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
            pin_prev_reg <= '1;
        end else begin
            pin_meta_reg <= {host_cs_n, host_wr_n, host_rd_n, host_addr, host_data_in};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // write completes on the rising edge of the write strobe
    assign s_cs_n = pin_sync_reg[21];
    assign s_rd_n = pin_sync_reg[19];
    assign s_addr = pin_sync_reg[18:16];
    assign s_data = pin_sync_reg[15:0];
    assign wr_end = pin_sync_reg[20] && !pin_prev_reg[20] && !s_cs_n && !pin_prev_reg[21];

    // register state
    logic [31:0] hold_reg, hold_next;
    logic [15:0] read_addr_reg, read_addr_next;
    logic [15:0] test_reg, test_next;
    logic [31:0] fetched_reg, fetched_next;
    logic [3:0][15:0] agc_hold_reg, agc_hold_next;
    logic [ORDER_WIDTH-1:0] order_reg [ORDER_DEPTH];
    logic [ORDER_WIDTH-1:0] order_next [ORDER_DEPTH];
    logic sync_next, enable_pulse_next, fetch_next, agc_next;
    logic [3:0] enable_out_next;
    logic [15:0] out_next, order_out_next;
    logic oe_n_next;
    logic enable_pulse_reg;
    logic is_write_addr, is_global;
    logic [1:0] rd_chan;
    logic [11:0] rd_ofs;
    logic [31:0] live_word;

    assign is_write_addr = wr_end && (s_addr == DIR_WRITE_ADDR);
    assign is_global = (s_data[15:12] == NIBBLE_GLOBAL);
    assign rd_chan = read_addr_reg[13:12];
    assign rd_ofs = read_addr_reg[11:0];

    // next values for host writes, strobes and capture
    always_comb begin
        hold_next = hold_reg;
        read_addr_next = read_addr_reg;
        test_next = test_reg;
        fetched_next = fetched_reg;
        agc_hold_next = agc_hold_reg;
        order_next = order_reg;
        sync_next = 1'b0;
        enable_pulse_next = 1'b0;
        fetch_next = 1'b0;
        agc_next = 1'b0;
        if (wr_end && s_addr == DIR_HOLD_LO) begin
            hold_next[15:0] = s_data;
        end
        if (wr_end && s_addr == DIR_HOLD_HI) begin
            hold_next[31:16] = s_data;
        end
        if (is_write_addr && is_global) begin
            if (s_data == GLOBAL_TEST_INPUT) begin
                test_next = hold_reg[15:0];
            end
            // data bus ignored at strobe locations
            enable_pulse_next = (s_data == GLOBAL_TEST_STROBE);
            sync_next = (s_data == GLOBAL_SYNC_STROBE);
            if (s_data >= GLOBAL_ORDER_BASE && s_data <= GLOBAL_ORDER_LAST) begin
                order_next[s_data[4:0]] = hold_reg[4:0];
            end
        end
        if (is_write_addr && !is_global && s_data[11:0] == IOFS_AGC) begin
            // one write samples every channel at once
            agc_next = 1'b1;
            agc_hold_next = agc_gain;
        end
        if (wr_end && s_addr == DIR_INDIRECT_READ) begin
            read_addr_next = s_data;
            fetched_next = LONG_RESET;
            if (s_data[15:12] == NIBBLE_ALL || chan_valid(s_data[15:12])) begin
                case (s_data[11:0])
                    IOFS_CARRIER: fetched_next = carrier_freq[s_data[13:12]];
                    IOFS_TIMING: fetched_next = timing_freq[s_data[13:12]];
                    IOFS_WAIT: fetched_next = wait_values[s_data[13:12]];
                    default: fetched_next = LONG_RESET;
                endcase
            end
            // stabilise strobe for snapshot sources
            fetch_next = (s_data[11:0] == IOFS_CARRIER || s_data[11:0] == IOFS_TIMING
                          || s_data[11:0] == IOFS_WAIT);
        end
    end

    // live read sources selected by the indirect address
    always_comb begin
        live_word = fetched_reg;
        if (read_addr_reg == LEVEL_READ_ADDR) begin
            live_word = level_out;
        end else if (!(read_addr_reg[15:12] == NIBBLE_ALL || chan_valid(read_addr_reg[15:12]))) begin
            live_word = LONG_RESET;
        end else if (rd_ofs == IOFS_AGC) begin
            live_word = {16'h0000, agc_hold_reg[rd_chan]};
        end else if (read_addr_reg[15:12] == NIBBLE_ALL && rd_ofs >= GLOBAL_ORDER_BASE[11:0]
                     && rd_ofs <= GLOBAL_ORDER_LAST[11:0]) begin
            live_word = {27'h000_0000, order_reg[rd_ofs[4:0]]};
        end
    end

    // outputs: read data, enables, read order lookup
    always_comb begin
        oe_n_next = !(!s_cs_n && !s_rd_n && (s_addr == DIR_READ_LO || s_addr == DIR_READ_HI));
        out_next = (s_addr == DIR_READ_HI) ? live_word[31:16] : live_word[15:0];
        for (int c = 0; c < 4; c++) begin
            enable_out_next[c] = strobe_select[c] ? enable_pulse_reg : enable_level[c];
        end
        order_out_next = order_word(order_reg[order_index][2:0], path_i[order_reg[order_index][4:3]],
                                    path_q[order_reg[order_index][4:3]], path_mag[order_reg[order_index][4:3]],
                                    path_phase[order_reg[order_index][4:3]],
                                    agc_hold_reg[order_reg[order_index][4:3]]);
    end

    // register everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= LONG_RESET;
            read_addr_reg <= WORD_RESET;
            test_reg <= WORD_RESET;
            fetched_reg <= LONG_RESET;
            agc_hold_reg <= '0;
            for (int k = 0; k < ORDER_DEPTH; k++) begin
                order_reg[k] <= ORDER_RESET;
            end
            sync_out_pin <= 1'b0;
            enable_pulse_reg <= 1'b0;
            fetch_strobe <= 1'b0;
            agc_sample_strobe <= 1'b0;
            input_enable_strobe <= 4'h0;
            host_data_out <= WORD_RESET;
            host_data_oe_n <= 1'b1;
            order_data <= WORD_RESET;
        end else begin
            hold_reg <= hold_next;
            read_addr_reg <= read_addr_next;
            test_reg <= test_next;
            fetched_reg <= fetched_next;
            agc_hold_reg <= agc_hold_next;
            order_reg <= order_next;
            sync_out_pin <= sync_next;
            enable_pulse_reg <= enable_pulse_next;
            fetch_strobe <= fetch_next;
            agc_sample_strobe <= agc_next;
            input_enable_strobe <= enable_out_next;
            host_data_out <= out_next;
            host_data_oe_n <= oe_n_next;
            order_data <= order_out_next;
        end
    end

    assign test_input = test_reg;

    // sync pulse is one cycle wide
    property p_sync_one_cycle;
        @(posedge clk) disable iff (!rst_n) sync_out_pin |=> !sync_out_pin;
    endproperty
    a_sync_one_cycle: assert property (p_sync_one_cycle) else $error("sync pulse too wide");

    // sync pulse follows a sync strobe write
    property p_sync_cause;
        @(posedge clk) disable iff (!rst_n)
            $rose(sync_out_pin) |-> $past(is_write_addr && s_data == GLOBAL_SYNC_STROBE);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("sync pulse without strobe");

    // strobe write reaches enable 0, when selected, two cycles later
    property p_enable_strobe;
        @(posedge clk) disable iff (!rst_n)
            (is_write_addr && s_data == GLOBAL_TEST_STROBE) ##1 strobe_select[0] |=> input_enable_strobe[0];
    endproperty
    a_enable_strobe: assert property (p_enable_strobe) else $error("enable strobe missing");

    // strobe writes leave held data alone
    property p_strobe_no_store;
        @(posedge clk) disable iff (!rst_n)
            (is_write_addr && (s_data == GLOBAL_TEST_STROBE || s_data == GLOBAL_SYNC_STROBE)) |=> $stable(test_reg);
    endproperty
    a_strobe_no_store: assert property (p_strobe_no_store) else $error("strobe write stored data");

    // indirect address write latches the address
    property p_read_addr_write;
        @(posedge clk) disable iff (!rst_n)
            (wr_end && s_addr == DIR_INDIRECT_READ) |=> (read_addr_reg == $past(s_data));
    endproperty
    a_read_addr_write: assert property (p_read_addr_write) else $error("indirect address not taken");

    // fetch strobe only after an indirect address write
    property p_fetch_cause;
        @(posedge clk) disable iff (!rst_n) fetch_strobe |-> $past(wr_end && s_addr == DIR_INDIRECT_READ);
    endproperty
    a_fetch_cause: assert property (p_fetch_cause) else $error("fetch strobe without write");

    // gain sample strobe follows an indirect gain write
    property p_agc_strobe;
        @(posedge clk) disable iff (!rst_n)
            (is_write_addr && !is_global && s_data[11:0] == IOFS_AGC) |=> agc_sample_strobe ##1 !agc_sample_strobe;
    endproperty
    a_agc_strobe: assert property (p_agc_strobe) else $error("gain sample strobe wrong");

    // level detector output read live
    property p_level_live;
        @(posedge clk) disable iff (!rst_n)
            (read_addr_reg == LEVEL_READ_ADDR && s_addr == DIR_READ_LO)
            |=> (host_data_out == $past(level_out[15:0]));
    endproperty
    a_level_live: assert property (p_level_live) else $error("level output not live");

    // invalid channel nibble reads zero
    property p_bad_nibble;
        @(posedge clk) disable iff (!rst_n)
            (read_addr_reg[15:14] != 2'b00 && read_addr_reg[15:12] != NIBBLE_ALL)
            |=> (host_data_out == WORD_RESET);
    endproperty
    a_bad_nibble: assert property (p_bad_nibble) else $error("invalid channel returned data");
endmodule

// file: rtl/hsr_pkg.sv
// constants and helpers for the host strobe and indirect read block
package hsr_pkg;
    // direct host port addresses
    localparam logic [2:0] DIR_READ_LO = 3'h0;
    localparam logic [2:0] DIR_READ_HI = 3'h1;
    localparam logic [2:0] DIR_WRITE_ADDR = 3'h2;
    localparam logic [2:0] DIR_INDIRECT_READ = 3'h3;
    localparam logic [2:0] DIR_HOLD_LO = 3'h4;
    localparam logic [2:0] DIR_HOLD_HI = 3'h5;
    // global write addresses
    localparam logic [15:0] GLOBAL_TEST_INPUT = 16'hf807;
    localparam logic [15:0] GLOBAL_TEST_STROBE = 16'hf808;
    localparam logic [15:0] GLOBAL_SYNC_STROBE = 16'hf809;
    localparam logic [15:0] GLOBAL_ORDER_BASE = 16'hf820;
    localparam logic [15:0] GLOBAL_ORDER_LAST = 16'hf83f;
    // indirect addresses, low 12 bits per channel
    localparam logic [11:0] IOFS_CARRIER = 12'h006;
    localparam logic [11:0] IOFS_TIMING = 12'h009;
    localparam logic [11:0] IOFS_WAIT = 12'h00c;
    localparam logic [11:0] IOFS_AGC = 12'h00f;
    localparam logic [15:0] LEVEL_READ_ADDR = 16'hf806;
    localparam logic [3:0] NIBBLE_ALL = 4'hf;
    localparam logic [3:0] NIBBLE_GLOBAL = 4'hf;
    // field layout
    localparam int ORDER_WIDTH = 5;
    localparam int ORDER_DEPTH = 32;
    localparam int STROBE_SELECT_BIT = 12;
    // reset values
    localparam logic [4:0] ORDER_RESET = 5'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [31:0] LONG_RESET = 32'h0000_0000;

    // readback word for one read order entry
    function automatic logic [15:0] order_word(input logic [2:0] dtype, input logic [23:0] i_d,
                                               input logic [23:0] q_d, input logic [23:0] mag,
                                               input logic [15:0] phase, input logic [15:0] gain);
        case (dtype)
            3'b000: order_word = i_d[23:8];
            3'b001: order_word = {i_d[7:0], 8'h00};
            3'b010: order_word = q_d[23:8];
            3'b011: order_word = {q_d[7:0], 8'h00};
            3'b100: order_word = mag[23:8];
            3'b101: order_word = {mag[7:0], 8'h00};
            3'b110: order_word = phase;
            default: order_word = gain;
        endcase
    endfunction

    // nibble names one channel, 0..3
    function automatic logic chan_valid(input logic [3:0] nib);
        chan_valid = (nib[3:2] == 2'b00);
    endfunction
endpackage

// file: bench/hsr_host_model.sv
// microprocessor model driving the host port pins of the block
`timescale 1ns/1ps
module hsr_host_model (
    // clock
    input wire logic clk,
    // host port pins
    output logic host_cs_n,
    output logic host_wr_n,
    output logic host_rd_n,
    output logic [2:0] host_addr,
    output logic [15:0] host_data_in,
    input wire logic [15:0] host_data_out,
    input wire logic host_data_oe_n
);
    // control and address pins idle high, data pins hold 5a5a
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_addr = 3'h7;
        host_data_in = 16'h5a5a;
    end
    // one direct write, held past the pin synchronisers
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        host_addr = a;
        host_data_in = d;
        host_cs_n = 1'b0;
        host_wr_n = 1'b0;
        repeat (4) @(negedge clk);
        host_wr_n = 1'b1;
        repeat (4) @(negedge clk);
        host_cs_n = 1'b1;
        host_data_in = ~d; // released bus shows a changed value
        repeat (2) @(negedge clk);
    endtask
    // global write: hold low, hold high, then target address
    task automatic glob(input logic [15:0] a, input logic [31:0] d);
        wr(3'h4, d[15:0]);
        wr(3'h5, d[31:16]);
        wr(3'h2, a);
    endtask
    // read address rewritten before every read of strobed data
    task automatic iread(input logic [15:0] a);
        wr(3'h3, a);
    endtask
    // one direct read, sampled after the answer has settled
    task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic oe_n);
        host_addr = a;
        host_cs_n = 1'b0;
        host_rd_n = 1'b0;
        repeat (6) @(negedge clk);
        d = host_data_out;
        oe_n = host_data_oe_n;
        host_rd_n = 1'b1;
        host_cs_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // low half at address 0, high half at address 1
    task automatic rd32(output logic [31:0] v, output logic oe_n);
        logic o0, o1;
        rd(3'h0, v[15:0], o0);
        rd(3'h1, v[31:16], o1);
        oe_n = o0 | o1;
    endtask
endmodule

// file: bench/testbench.sv
// self-checking bench for the host strobe and indirect read block
`timescale 1ns/1ps
module testbench;
    import hsr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_cs_n, host_wr_n, host_rd_n, host_data_oe_n, sync_out_pin, fetch_strobe, agc_sample_strobe, oe_n;
    logic [2:0] host_addr;
    logic [15:0] host_data_in, host_data_out, test_input, order_data;
    logic [3:0] strobe_select = 4'h0;
    logic [3:0] enable_level = 4'h0;
    logic [3:0] input_enable_strobe;
    logic [3:0][31:0] carrier_freq, timing_freq, wait_values;
    logic [3:0][23:0] path_i, path_q, path_mag;
    logic [3:0][15:0] agc_gain, path_phase, gain_held;
    logic [31:0] level_out, v, tv;
    logic [31:0] seed = 32'h0000_16b1;
    logic [4:0] order_index = 5'h00;
    logic [4:0] ent [8];
    logic [6:0] strb;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int pulses [7] = '{default: 0};
    int base [7];

    always #4 clk = ~clk;

    hsr_host_strobe_read uut (
        .clk(clk), .rst_n(rst_n), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe_n(host_data_oe_n), .strobe_select(strobe_select), .enable_level(enable_level),
        .carrier_freq(carrier_freq), .timing_freq(timing_freq), .wait_values(wait_values), .agc_gain(agc_gain),
        .path_i(path_i), .path_q(path_q), .path_mag(path_mag), .path_phase(path_phase), .level_out(level_out),
        .order_index(order_index), .order_data(order_data), .test_input(test_input),
        .input_enable_strobe(input_enable_strobe), .sync_out_pin(sync_out_pin), .fetch_strobe(fetch_strobe),
        .agc_sample_strobe(agc_sample_strobe)
    );
    hsr_host_model host (
        .clk(clk), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .host_addr(host_addr),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n)
    );

    // count the cycles each strobe stands high
    assign strb = {input_enable_strobe, agc_sample_strobe, fetch_strobe, sync_out_pin};
    always @(posedge clk) begin
        for (int k = 0; k < 7; k++) if (strb[k] === 1'b1) pulses[k]++;
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected word of one order entry
    function automatic logic [15:0] exp_order(input logic [4:0] e);
        logic [1:0] c;
        c = e[4:3];
        case (e[2:0])
            3'h0: return path_i[c][23:8];
            3'h1: return {path_i[c][7:0], 8'h00};
            3'h2: return path_q[c][23:8];
            3'h3: return {path_q[c][7:0], 8'h00};
            3'h4: return path_mag[c][23:8];
            3'h5: return {path_mag[c][7:0], 8'h00};
            3'h6: return path_phase[c];
            default: return gain_held[c];
        endcase
    endfunction
    function automatic logic [31:0] exp_src(input logic [11:0] ofs, input logic [1:0] c);
        return (ofs == IOFS_CARRIER) ? carrier_freq[c] : (ofs == IOFS_TIMING) ? timing_freq[c] : wait_values[c];
    endfunction
    // fresh random datapath sources
    task automatic shuffle();
        for (int c = 0; c < 4; c++) begin
            carrier_freq[c] = rnd();
            timing_freq[c] = rnd();
            wait_values[c] = rnd();
            agc_gain[c] = 16'(rnd());
            path_i[c] = 24'(rnd());
            path_q[c] = 24'(rnd());
            path_mag[c] = 24'(rnd());
            path_phase[c] = 16'(rnd());
        end
        level_out = rnd();
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        logic [1:0] ch;
        logic [3:0] nib;
        logic [11:0] ofs;
        shuffle();
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("oe idle", 1, host_data_oe_n);
        // gain sampled by its own write, later changes ignored
        base = pulses;
        host.wr(3'h2, {4'h0, IOFS_AGC});
        check("gain strobe", base[2] + 1, pulses[2]);
        gain_held = agc_gain;
        shuffle();
        ch = 2'(rnd());
        host.iread({2'b00, ch, IOFS_AGC});
        host.rd32(v, oe_n);
        check("gain read", {16'h0000, gain_held[ch]}, v);
        check("read enable", 0, oe_n);
        // every data type, last entry included
        for (int k = 0; k < 8; k++) begin
            ent[k] = {2'(rnd()), 3'(k)};
            host.glob(GLOBAL_ORDER_BASE + 16'(k * 4 + 3), {27'(rnd()), ent[k]});
        end
        for (int k = 0; k < 8; k++) begin
            order_index = 5'(k * 4 + 3);
            repeat (2) @(negedge clk);
            check("order entry", exp_order(ent[k]), order_data);
        end
        // last entry read back through the indirect path
        host.iread(GLOBAL_ORDER_LAST);
        host.rd32(v, oe_n);
        check("order readback", {27'h000_0000, ent[7]}, v);
        // test input word, then sync and enable strobes with other data
        base = pulses;
        tv = rnd();
        host.glob(GLOBAL_TEST_INPUT, tv);
        check("test input", tv[15:0], test_input);
        host.glob(GLOBAL_SYNC_STROBE, ~tv);
        check("sync pulse", base[0] + 1, pulses[0]);
        for (int n = 0; n < 2; n++) begin
            strobe_select = n ? ~strobe_select : 4'(rnd());
            enable_level = 4'(rnd());
            repeat (3) @(negedge clk);
            base = pulses;
            host.glob(GLOBAL_TEST_STROBE, ~tv);
            for (int c = 0; c < 4; c++)
                if (strobe_select[c]) check("enable strobe", base[3 + c] + 1, pulses[3 + c]);
                else check("enable level", enable_level[c], input_enable_strobe[c]);
        end
        check("test input kept", tv[15:0], test_input);
        // snapshot sources, channel nibble F takes its low two bits, channel 3
        for (int n = 0; n < 4; n++) begin
            ofs = (n == 1) ? IOFS_TIMING : (n == 2) ? IOFS_WAIT : IOFS_CARRIER;
            ch = (n == 3) ? 2'h3 : 2'(rnd());
            nib = (n == 3) ? NIBBLE_ALL : {2'b00, ch};
            base = pulses;
            host.iread({nib, ofs});
            check("fetch strobe", base[1] + 1, pulses[1]);
            tv = exp_src(ofs, ch);
            shuffle();
            host.rd32(v, oe_n);
            check("snapshot read", tv, v);
        end
        // level detector read live without rewriting the address
        host.iread(LEVEL_READ_ADDR);
        host.rd32(v, oe_n);
        check("level read", level_out, v);
        level_out = rnd();
        host.rd32(v, oe_n);
        check("level live", level_out, v);
        host.iread({4'(4 + rnd() % 11), IOFS_CARRIER});
        host.rd32(v, oe_n);
        check("bad channel", 0, v);
        give_verdict();
    end
endmodule
